// ==== rtl/irr_pkg.sv ====
// constants and types shared by the infrared frame receiver
package irr_pkg;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned REF_HZ        = 4_000_000;
  // reference tick divider: core clock cycles per 4 MHz tick
  localparam int unsigned REF_DIV       = CLK_HZ / REF_HZ;
  // nominal widths in microseconds
  localparam int unsigned START_US      = 2400;
  localparam int unsigned ONE_US        = 1200;
  localparam int unsigned ZERO_US       = 600;
  localparam int unsigned MS_US         = 1000;
  // widths in reference ticks
  localparam int unsigned START_TICKS   = START_US * (REF_HZ / 1_000_000);
  localparam int unsigned ONE_TICKS     = ONE_US * (REF_HZ / 1_000_000);
  localparam int unsigned ZERO_TICKS    = ZERO_US * (REF_HZ / 1_000_000);
  localparam int unsigned MS_TICKS      = MS_US * (REF_HZ / 1_000_000);
  // acceptance window around each nominal width, in ticks (+/- 0.2 ms)
  localparam int unsigned TOL_TICKS     = 800;
  localparam int unsigned CMD_BITS      = 7;
  localparam int unsigned ID_BITS       = 5;
  localparam int unsigned FRAME_BITS    = CMD_BITS + ID_BITS;
  localparam logic [6:0]  CMD_RESET     = 7'h00;
  typedef enum logic [2:0] {IRR_IDLE, IRR_WAIT_START, IRR_START, IRR_WAIT_BIT,
                            IRR_BIT, IRR_DONE} irr_state_t;
endpackage : irr_pkg

// ==== rtl/irr_tick_gen.sv ====
// fixed 4 MHz reference tick derived from the core clock
`timescale 1ns/10ps
module irr_tick_gen
  import irr_pkg::*;
#(
  parameter int unsigned DIV = REF_DIV
) (
  input  wire logic core_clk,
  input  wire logic rst,
  output logic      tick
);
  logic [7:0] cnt;

  // independent of any program clock setting, so pulse timing never shifts
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt  <= 8'h00;
      tick <= 1'b0;
    end else if (cnt == 8'(DIV - 1)) begin
      cnt  <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule : irr_tick_gen

// ==== rtl/irr_receiver.sv ====
// infrared remote frame receiver: pulse-width decode with millisecond timeout
`timescale 1ns/10ps
// Notes on behaviour
// - request blocks until a whole new frame is captured, then done pulses.
// - optional timeout in milliseconds limits the wait; zero means wait forever.
// - timeout expiry ends the wait and pulses timed_out, no done; a twelfth bit ending in that same cycle still loads its data.
// - decoded 7-bit command 0..127 placed in the result register.
// - frame: 2.4 ms start, seven command bits, five id bits, lsb first.
// - input pin chosen by a select value at request time.
// - remote handsets and controller transmitters are decoded the same way.
// - widths timed by a fixed 4 MHz reference from the core clock.
module irr_receiver
  import irr_pkg::*;
#(
  parameter int unsigned NUM_PINS = 8,
  parameter int unsigned SEL_W    = 3,
  // divides every nominal width and the millisecond count; 1 keeps the real timing,
  // larger values only shorten runs and coarsen the tolerance in proportion
  parameter int unsigned TIME_DIV = 1
) (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic [NUM_PINS-1:0] ir_pins,
  input  wire logic [SEL_W-1:0]    pin_sel,
  input  wire logic                start_req,
  input  wire logic [15:0]         timeout_ms,
  output logic                     busy,
  output logic                     done,
  output logic                     timed_out,
  output logic [6:0]               command,
  output logic [4:0]               device_id
);
  logic [NUM_PINS-1:0] pin_meta;
  logic [NUM_PINS-1:0] pin_sync;
  logic [SEL_W-1:0]    sel;
  logic [15:0]         tmo_limit;
  logic [15:0]         ms_count;
  logic [13:0]         ms_ticks;
  logic [13:0]         width;
  logic [3:0]          bit_idx;
  logic [11:0]         shreg;
  logic                tick;
  logic                ir_level;
  logic                ms_tick;
  logic                tmo_hit;
  logic                start_ok;
  logic                bit_one;
  logic                bit_zero;
  irr_state_t          state;

  irr_tick_gen #(.DIV(REF_DIV)) u_tick (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick)
  );

  // receiver module output is active high while ir carrier is present
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= ir_pins;
      pin_sync <= pin_meta;
    end
  end

  assign ir_level = pin_sync[sel];

  function automatic logic in_window(input logic [13:0] w, input int unsigned nom);
    in_window = (int'(w) + TOL_TICKS / TIME_DIV >= nom)
                && (int'(w) <= nom + TOL_TICKS / TIME_DIV);
  endfunction : in_window

  assign start_ok = in_window(width, START_TICKS / TIME_DIV);
  // both handsets and controllers use the same widths, so one decoder serves
  assign bit_one  = in_window(width, ONE_TICKS / TIME_DIV);
  assign bit_zero = in_window(width, ZERO_TICKS / TIME_DIV) && !bit_one;

  assign ms_tick = tick && (ms_ticks == 14'(MS_TICKS / TIME_DIV - 1));
  assign tmo_hit = (tmo_limit != 16'h0000) && (ms_count >= tmo_limit);
  assign busy    = (state != IRR_IDLE) && (state != IRR_DONE);

  // millisecond timer runs from request until the frame ends
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ms_ticks <= 14'h0000;
      ms_count <= 16'h0000;
    end else if (!busy) begin
      ms_ticks <= 14'h0000;
      ms_count <= 16'h0000;
    end else if (tick) begin
      ms_ticks <= ms_tick ? 14'h0000 : ms_ticks + 14'h0001;
      if (ms_tick && ms_count != 16'hFFFF)
        ms_count <= ms_count + 16'h0001;
    end
  end

  // pulse width counter, saturating so a stuck carrier cannot wrap into a valid width
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      width <= 14'h0000;
    end else if (!ir_level) begin
      width <= 14'h0000;
    end else if (tick && width != 14'h3FFF) begin
      width <= width + 14'h0001;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state     <= IRR_IDLE;
      sel       <= '0;
      tmo_limit <= 16'h0000;
      bit_idx   <= 4'h0;
      shreg     <= 12'h000;
      done      <= 1'b0;
      timed_out <= 1'b0;
    end else begin
      done      <= 1'b0;
      timed_out <= 1'b0;
      if (busy && tmo_hit) begin
        state     <= IRR_IDLE;
        timed_out <= 1'b1;
      end else begin
        unique case (state)
          IRR_IDLE, IRR_DONE: begin
            if (start_req) begin
              sel       <= pin_sel;
              tmo_limit <= timeout_ms;
              state     <= IRR_WAIT_START;
            end else begin
              state <= IRR_IDLE;
            end
          end
          // a frame already in flight at request time is skipped: only a new one counts
          IRR_WAIT_START: if (ir_level && width == 14'h0000) state <= IRR_START;
          IRR_START: begin
            if (!ir_level) begin
              bit_idx <= 4'h0;
              state   <= start_ok ? IRR_WAIT_BIT : IRR_WAIT_START;
            end
          end
          IRR_WAIT_BIT: if (ir_level) state <= IRR_BIT;
          IRR_BIT: begin
            if (!ir_level) begin
              if (!(bit_one || bit_zero)) begin
                state <= IRR_WAIT_START;
              end else begin
                shreg   <= {bit_one, shreg[11:1]};
                bit_idx <= bit_idx + 4'h1;
                if (bit_idx == 4'(FRAME_BITS - 1)) begin
                  state <= IRR_DONE;
                  done  <= 1'b1;
                end else begin
                  state <= IRR_WAIT_BIT;
                end
              end
            end
          end
        endcase
      end
    end
  end

  // results update only on a complete frame, even one ending in the timeout cycle; other timeouts leave the last good value
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      command   <= CMD_RESET;
      device_id <= 5'h00;
    end else if (state == IRR_BIT && !ir_level && (bit_one || bit_zero)
                 && bit_idx == 4'(FRAME_BITS - 1)) begin
      // the twelfth bit has not been shifted in yet, so it still sits on bit_one
      command   <= shreg[7:1];
      device_id <= {bit_one, shreg[11:8]};
    end
  end

  a_done_one_cycle: assert property (@(posedge core_clk) disable iff (rst)
    done |=> !done) else $error("done held longer than one cycle");
  a_done_not_tmo: assert property (@(posedge core_clk) disable iff (rst)
    !(done && timed_out)) else $error("done and timeout together");
  a_tmo_after_busy: assert property (@(posedge core_clk) disable iff (rst)
    timed_out |-> $past(busy) && !busy) else $error("timeout without a wait");
  a_tmo_needs_limit: assert property (@(posedge core_clk) disable iff (rst)
    timed_out |-> tmo_limit != 16'h0000) else $error("timeout with no limit set");
  a_done_last_bit: assert property (@(posedge core_clk) disable iff (rst)
    done |-> !busy && $past(state) == IRR_BIT && $past(bit_idx) == 4'(FRAME_BITS - 1))
    else $error("done without a twelfth bit");
  a_cmd_stable: assert property (@(posedge core_clk) disable iff (rst)
    !done && !$past(done) |-> $stable(command)) else $error("command changed unprompted");
  a_bad_pulse_drop: assert property (@(posedge core_clk) disable iff (rst)
    state == IRR_START && !ir_level && !start_ok && !tmo_hit |=> state == IRR_WAIT_START)
    else $error("bad start pulse not dropped");
  a_tick_period: assert property (@(posedge core_clk) disable iff (rst)
    tick |=> !tick [*4] ##1 tick) else $error("reference tick period wrong");

  // request handshake, timeout, frame rejection and result stability
  a_sel_hold: assert property (@(posedge core_clk) disable iff (rst)
    busy |=> $stable(sel) && $stable(tmo_limit)) else $error("selection changed while busy");
  a_busy_on_req: assert property (@(posedge core_clk) disable iff (rst)
    !busy && start_req |=> busy) else $error("request not taken");
  a_tmo_ends: assert property (@(posedge core_clk) disable iff (rst)
    busy && tmo_hit |=> timed_out && !busy) else $error("timeout did not end the wait");
  a_bad_bit_drop: assert property (@(posedge core_clk) disable iff (rst)
    state == IRR_BIT && !ir_level && !(bit_one || bit_zero) && !tmo_hit
    |=> state == IRR_WAIT_START) else $error("bad bit pulse not dropped");
  a_id_stable: assert property (@(posedge core_clk) disable iff (rst)
    !done && !$past(done) |-> $stable(device_id)) else $error("device id changed unprompted");

  c_frame_done: cover property (@(posedge core_clk) disable iff (rst) done);
  c_timeout: cover property (@(posedge core_clk) disable iff (rst) timed_out);
  c_reject: cover property (@(posedge core_clk) disable iff (rst)
    state == IRR_BIT ##1 state == IRR_WAIT_START);
  c_start_reject: cover property (@(posedge core_clk) disable iff (rst)
    state == IRR_START && !ir_level && !start_ok);
  c_req_while_busy: cover property (@(posedge core_clk) disable iff (rst) busy && start_req);
endmodule : irr_receiver

// ==== tb/irr_tx_model.sv ====
// infrared transmitter model: drives demodulated carrier levels on the pins
`timescale 1ns/10ps
module irr_tx_model #(
  parameter int unsigned TIME_DIV = 1
) (
  output logic [7:0] ir_pins
);
  // idle pins show no carrier, which the receiver sees as low
  initial ir_pins = 8'h00;

  // every width shrinks by the same factor as the receiver's own counts
  task automatic silence(input int us);
    #(us * 1000 / TIME_DIV);
  endtask : silence

  task automatic pulse(input int pin, input int us);
    ir_pins[pin] = 1'b1;
    silence(us);
    ir_pins[pin] = 1'b0;
  endtask : pulse

  task automatic send_frame(input int pin, input logic [6:0] cmd, input logic [4:0] id,
                            input int start_us);
    logic [11:0] bits;
    bits = {id, cmd};
    pulse(pin, start_us);
    for (int i = 0; i < 12; i++) begin
      silence(600);
      pulse(pin, bits[i] ? 1200 : 600);
    end
  endtask : send_frame
endmodule : irr_tx_model

// ==== tb/tb.sv ====
// testbench for the infrared frame receiver
`timescale 1ns/10ps
module tb;
  import irr_pkg::*;
  // widths and the millisecond shrink by this factor on both sides, so a run stays short
  localparam int unsigned TIME_DIV = 40;
  localparam int          TMO_CYC  = int'(MS_TICKS / TIME_DIV * REF_DIV);
  logic        core_clk   = 1'b0;
  logic        rst        = 1'b1;
  logic [7:0]  ir_pins;
  logic [2:0]  pin_sel    = 3'h0;
  logic        start_req  = 1'b0;
  logic [15:0] timeout_ms = 16'h0000;
  logic        busy, done, timed_out;
  logic [6:0]  command;
  logic [4:0]  device_id;
  int          err_total   = 0;
  int          check_count = 0;

  always #25 core_clk = ~core_clk;

  irr_receiver #(.TIME_DIV(TIME_DIV)) i_dut (.core_clk(core_clk), .rst(rst), .ir_pins(ir_pins),
    .pin_sel(pin_sel), .start_req(start_req), .timeout_ms(timeout_ms), .busy(busy), .done(done),
    .timed_out(timed_out), .command(command), .device_id(device_id));
  irr_tx_model #(.TIME_DIV(TIME_DIV)) i_tx (.ir_pins(ir_pins));

  task automatic check_value(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check_value

  task automatic conclude();
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic request(input logic [2:0] pin, input logic [15:0] tmo);
    @(posedge core_clk); #1;
    pin_sel = pin;
    timeout_ms = tmo;
    start_req = 1'b1;
    @(posedge core_clk); #1;
    start_req = 1'b0;
    check_value(busy, 1'b1);
  endtask : request

  task automatic wait_end(input int limit, output int n);
    n = 0;
    while (done !== 1'b1 && timed_out !== 1'b1 && n < limit) begin
      @(posedge core_clk); #1;
      n++;
    end
  endtask : wait_end

  task automatic test_frame();
    int n;
    request(3'h3, 16'h0000);
    // a second request with a short timeout must be ignored while busy
    @(posedge core_clk); #1;
    pin_sel = 3'h5;
    timeout_ms = 16'h0001;
    start_req = 1'b1;
    @(posedge core_clk); #1;
    start_req = 1'b0;
    i_tx.send_frame(3, 7'h55, 5'h01, START_US);
    wait_end(100, n);
    check_value(done, 1'b1);
    check_value(timed_out, 1'b0);
    check_value(command, 7'h55);
    check_value(device_id, 5'h01);
    @(posedge core_clk); #1;
    check_value({busy, done}, 2'b00);
  endtask : test_frame

  task automatic test_timeout();
    int n;
    request(3'h0, 16'h0001);
    wait_end(2000, n);
    check_value(timed_out, 1'b1);
    check_value(n >= TMO_CYC - 10 && n <= TMO_CYC + 10, 1'b1);
    check_value(command, 7'h55);
    @(posedge core_clk); #1;
    check_value(busy, 1'b0);
  endtask : test_timeout

  task automatic test_reject();
    int n;
    request(3'h6, 16'h0000);
    // start pulse far below the accepted width: frame must be dropped
    i_tx.send_frame(6, 7'h00, 5'h01, 1500);
    check_value({busy, done}, 2'b10);
    i_tx.silence(ZERO_US);
    // good start, then a bit pulse between the zero and one windows
    i_tx.pulse(6, START_US);
    i_tx.silence(ZERO_US);
    i_tx.pulse(6, 900);
    i_tx.silence(ZERO_US);
    check_value({busy, done}, 2'b10);
    i_tx.send_frame(6, 7'h7F, 5'h01, START_US);
    wait_end(100, n);
    check_value(done, 1'b1);
    check_value(command, 7'h7F);
    check_value(device_id, 5'h01);
  endtask : test_reject

  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    rst = 1'b0;
    check_value({busy, done, timed_out, command, device_id}, 15'h0000);
    test_frame();
    test_timeout();
    test_reject();
    conclude();
  end

  // the shrunk frames and timeout take about 1.6 ms; a 3 ms limit is ample
  initial begin
    #3_000_000;
    err_total++;
    conclude();
  end
endmodule : tb
